// ---- mds_pkg.sv ----
// Package for the DMA event status block: offsets, field positions, codes
`default_nettype none
package mds_pkg;
    localparam logic [7:0] DMA_EVENT_STATUS_OFS = 8'h28;
    localparam logic [7:0] IRQ_MASK_OFS         = 8'h38;
    localparam logic [7:0] TX_POLL_OFS          = 8'h08;
    localparam logic [7:0] RX_POLL_OFS          = 8'h10;
    localparam logic [7:0] TX_RX_CTRL_OFS       = 8'h30;
    // Field positions within dma_event_status, then the run and auto-poll bit positions of the tx/rx control register
    localparam int TX_DONE_BIT       = 0;
    localparam int TX_STOPPED_BIT    = 1;
    localparam int TX_DESC_UNAV_BIT  = 2;
    localparam int TX_JABBER_BIT     = 3;
    localparam int TX_UNDERFLOW_BIT  = 5;
    localparam int RX_DONE_BIT       = 6;
    localparam int RX_DESC_UNAV_BIT  = 7;
    localparam int RX_STOPPED_BIT    = 8;
    localparam int RX_WATCHDOG_BIT   = 9;
    localparam int GP_TIMER_BIT      = 11;
    localparam int FATAL_BUS_BIT     = 13;
    localparam int ABNORMAL_SUM_BIT  = 15;
    localparam int NORMAL_SUM_BIT    = 16;
    localparam int RX_STATE_LSB      = 17;
    localparam int TX_STATE_LSB      = 20;
    localparam int BUS_FAULT_LSB     = 23;
    localparam int TX_RUN_BIT        = 13;
    localparam int RX_RUN_BIT        = 1;
    localparam int TX_AUTOPOLL_BIT   = 0;
    // Bus fault kinds
    localparam logic [2:0] FAULT_PARITY       = 3'h0;
    localparam logic [2:0] FAULT_MASTER_ABORT = 3'h1;
    localparam logic [2:0] FAULT_TARGET_ABORT = 3'h2;
    // Transmit process state codes
    localparam logic [2:0] TXS_STOPPED   = 3'h0;
    localparam logic [2:0] TXS_READ_DESC = 3'h1;
    localparam logic [2:0] TXS_SENDING   = 3'h2;
    localparam logic [2:0] TXS_FILL      = 3'h3;
    localparam logic [2:0] TXS_SUSPENDED = 3'h6;
    localparam logic [2:0] TXS_WRITE_DSC = 3'h7;
    // Receive process state codes
    localparam logic [2:0] RXS_STOPPED   = 3'h0;
    localparam logic [2:0] RXS_READ_DESC = 3'h1;
    localparam logic [2:0] RXS_CHECK     = 3'h2;
    localparam logic [2:0] RXS_WAIT      = 3'h3;
    localparam logic [2:0] RXS_SUSPENDED = 3'h4;
    localparam logic [2:0] RXS_WRITE_DSC = 3'h5;
    localparam logic [2:0] RXS_FLUSH     = 3'h6;
    localparam logic [2:0] RXS_DRAIN     = 3'h7;
    // Reset values
    localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
    localparam logic [1:0]  MASK_RESET   = 2'h0;
    localparam logic [2:0]  CTRL_RESET   = 3'h0;
    // Transmit descriptor status word bits
    localparam int DESC_UNDERFLOW_BIT = 1;
    localparam int DESC_JABBER_BIT    = 14;
    localparam int DESC_IRQ_REQ_BIT   = 31;
endpackage
`default_nettype wire

// ---- mds_dma_status.sv ----
// DMA event status register with process state tracking and interrupt summary
//
// Summary of operation
// - Bus fault kind is valid only while fatal flag set; never interrupts.
// - Fault kind codes: 000 parity, 001 master abort, 010 target abort.
// - Transmit process state reported read-only in three bits, no interrupt.
// - Receive process state reported read-only in three bits, no interrupt.
// - Normal summary bit 16 set when tx done, tx unavailable or rx done set.
// - Abnormal summary bit 15 set when any abnormal event flag is set.
// - Bus fault sets fatal flag bit 13 and blocks all bus access until soft reset.
// - General timer expiry sets flag bit 11.
// - Receive watchdog timeout sets flag bit 9.
// - Receive process entering stopped sets flag bit 8.
// - Receive descriptor not owned sets bit 7 and suspends receive.
// - Receive resumes on poll demand with ownership, or on new frame.
// - Each completed frame reception sets flag bit 6.
// - Transmit underflow sets bit 5, suspends transmit, marks descriptor bit 1.
// - Jabber expiry sets bit 3, stops transmit, marks descriptor bit 14.
// - Transmit descriptor not owned sets bit 2 and suspends transmit.
// - Transmit resumes on ownership plus poll demand, or by auto-polling.
// - Transmit state becoming stopped sets flag bit 1.
// - Frame sent sets bit 0 only if its descriptor asks for an interrupt.
// - Flags stay set until software writes one; writing zero does nothing.
// - Normal enable bit gates the normal summary onto the interrupt output.
// - Abnormal enable bit gates the abnormal summary onto the interrupt output.
// - Poll demand write while suspended re-reads descriptor, resumes if owned.
//
// The strobed register port is this design's own decision.
`default_nettype none
module mds_dma_status
    import mds_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_rstn,
    input  wire logic [7:0]  i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [31:0] o_rdata,
    input  wire logic        i_soft_reset,
    input  wire logic        i_bus_fault,
    input  wire logic [2:0]  i_bus_fault_kind,
    input  wire logic        i_gp_timer_expired,
    input  wire logic        i_rx_watchdog_expired,
    input  wire logic        i_tx_desc_fetched,
    input  wire logic        i_tx_desc_owned,
    input  wire logic        i_tx_fill_done,
    input  wire logic        i_tx_underflow,
    input  wire logic        i_tx_jabber,
    input  wire logic        i_tx_frame_sent,
    input  wire logic        i_tx_irq_request,
    input  wire logic        i_tx_desc_written,
    input  wire logic        i_rx_desc_fetched,
    input  wire logic        i_rx_desc_owned,
    input  wire logic        i_rx_frame_start,
    input  wire logic        i_rx_frame_checked,
    input  wire logic        i_rx_frame_bad,
    input  wire logic        i_rx_drain_done,
    input  wire logic        i_rx_desc_written,
    input  wire logic        i_tx_autopoll_tick,
    output logic             o_bus_enable,
    output logic [2:0]       o_tx_process_state,
    output logic [2:0]       o_rx_process_state,
    output logic             o_tx_desc_status_we,
    output logic [31:0]      o_tx_desc_status_word,
    output logic             o_irq
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [16:0] flags;
        logic [2:0]  fault_kind;
        logic        bus_blocked;
        logic [2:0]  tx_state;
        logic [2:0]  rx_state;
        logic [1:0]  irq_mask;
        logic [2:0]  ctrl;
        logic [31:0] rdata;
        logic        desc_we;
        logic [31:0] desc_word;
        logic        irq;
    } mds_state_t;

    mds_state_t state_reg;
    mds_state_t state_next;

    logic [16:0] set_ev;
    logic [16:0] clr_ev;
    logic        wr_status;
    logic        tx_poll;
    logic        rx_poll;
    logic        tx_run;
    logic        rx_run;
    logic        norm_any;
    logic        abn_any;
    logic        fault_now;

    assign wr_status = i_wr && (i_addr == DMA_EVENT_STATUS_OFS);
    assign tx_poll   = i_wr && (i_addr == TX_POLL_OFS);
    assign rx_poll   = i_wr && (i_addr == RX_POLL_OFS);
    assign tx_run    = state_reg.ctrl[2];
    assign rx_run    = state_reg.ctrl[1];
    assign fault_now = i_bus_fault && !state_reg.bus_blocked;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        set_ev = 17'h0_0000;
        state_next.desc_we = 1'b0;
        state_next.desc_word = 32'h0000_0000;

        // Transmit process
        case (state_reg.tx_state)
            TXS_STOPPED: begin
                if (tx_run && !state_reg.bus_blocked) begin
                    state_next.tx_state = TXS_READ_DESC;
                end
            end
            TXS_READ_DESC: begin
                if (i_tx_desc_fetched) begin
                    if (i_tx_desc_owned) begin
                        state_next.tx_state = TXS_FILL;
                    end else begin
                        state_next.tx_state = TXS_SUSPENDED;
                        set_ev[TX_DESC_UNAV_BIT] = 1'b1;
                    end
                end
            end
            TXS_FILL: begin
                if (i_tx_fill_done) begin
                    state_next.tx_state = TXS_SENDING;
                end
            end
            TXS_SENDING: begin
                if (i_tx_frame_sent) begin
                    state_next.tx_state = TXS_WRITE_DSC;
                    set_ev[TX_DONE_BIT] = i_tx_irq_request;
                end
            end
            TXS_SUSPENDED: begin
                if (tx_poll || (state_reg.ctrl[TX_AUTOPOLL_BIT] && i_tx_autopoll_tick)) begin
                    state_next.tx_state = TXS_READ_DESC;
                end
            end
            TXS_WRITE_DSC: begin
                if (i_tx_desc_written) begin
                    state_next.tx_state = TXS_READ_DESC;
                end
            end
            default: begin
                state_next.tx_state = TXS_STOPPED;
            end
        endcase

        // Underflow suspends, jabber stops, both record in the descriptor
        if (i_tx_underflow && state_reg.tx_state == TXS_SENDING) begin
            state_next.tx_state = TXS_SUSPENDED;
            set_ev[TX_UNDERFLOW_BIT] = 1'b1;
            state_next.desc_we = 1'b1;
            state_next.desc_word[DESC_UNDERFLOW_BIT] = 1'b1;
        end
        if (i_tx_jabber) begin
            state_next.tx_state = TXS_STOPPED;
            set_ev[TX_JABBER_BIT] = 1'b1;
            state_next.desc_we = 1'b1;
            state_next.desc_word[DESC_JABBER_BIT] = 1'b1;
        end
        if (!tx_run || state_reg.bus_blocked) begin
            state_next.tx_state = TXS_STOPPED;
        end

        // Receive process
        case (state_reg.rx_state)
            RXS_STOPPED: begin
                if (rx_run && !state_reg.bus_blocked) begin
                    state_next.rx_state = RXS_READ_DESC;
                end
            end
            RXS_READ_DESC: begin
                if (i_rx_desc_fetched) begin
                    if (i_rx_desc_owned) begin
                        state_next.rx_state = RXS_WAIT;
                    end else begin
                        state_next.rx_state = RXS_SUSPENDED;
                        set_ev[RX_DESC_UNAV_BIT] = 1'b1;
                    end
                end
            end
            RXS_WAIT: begin
                if (i_rx_frame_start) begin
                    state_next.rx_state = RXS_DRAIN;
                end
            end
            RXS_DRAIN: begin
                if (i_rx_drain_done) begin
                    state_next.rx_state = RXS_CHECK;
                end
            end
            RXS_CHECK: begin
                if (i_rx_frame_checked) begin
                    state_next.rx_state = i_rx_frame_bad ? RXS_FLUSH : RXS_WRITE_DSC;
                end
            end
            RXS_FLUSH: begin
                state_next.rx_state = RXS_WAIT;
            end
            RXS_WRITE_DSC: begin
                if (i_rx_desc_written) begin
                    state_next.rx_state = RXS_READ_DESC;
                    set_ev[RX_DONE_BIT] = 1'b1;
                end
            end
            RXS_SUSPENDED: begin
                if (rx_poll || i_rx_frame_start) begin
                    state_next.rx_state = RXS_READ_DESC;
                end
            end
            default: begin
                state_next.rx_state = RXS_STOPPED;
            end
        endcase
        // Run-bit stop takes effect only outside an active reception; a bus block stops in any state
        if ((!rx_run && (state_reg.rx_state == RXS_WAIT || state_reg.rx_state == RXS_SUSPENDED
                || state_reg.rx_state == RXS_READ_DESC)) || state_reg.bus_blocked) begin
            state_next.rx_state = RXS_STOPPED;
        end

        // Entry into stopped states
        if (state_next.tx_state == TXS_STOPPED && state_reg.tx_state != TXS_STOPPED) begin
            set_ev[TX_STOPPED_BIT] = 1'b1;
        end
        if (state_next.rx_state == RXS_STOPPED && state_reg.rx_state != RXS_STOPPED) begin
            set_ev[RX_STOPPED_BIT] = 1'b1;
        end
        set_ev[GP_TIMER_BIT]    = i_gp_timer_expired;
        set_ev[RX_WATCHDOG_BIT] = i_rx_watchdog_expired;

        if (i_soft_reset) begin
            state_next.bus_blocked = 1'b0;
        end
        // Fatal fault: latch kind once and cut the bus until soft reset; beside the reset a first fault wins, a repeat fault loses
        if (fault_now) begin
            set_ev[FATAL_BUS_BIT] = 1'b1;
            state_next.bus_blocked = 1'b1;
            state_next.fault_kind = i_bus_fault_kind;
        end

        // Summaries follow the events; both latch like any flag
        norm_any = state_reg.flags[TX_DONE_BIT] | state_reg.flags[TX_DESC_UNAV_BIT]
                 | state_reg.flags[RX_DONE_BIT] | set_ev[TX_DONE_BIT]
                 | set_ev[TX_DESC_UNAV_BIT] | set_ev[RX_DONE_BIT];
        abn_any  = |(({state_reg.flags[FATAL_BUS_BIT], state_reg.flags[GP_TIMER_BIT],
                      state_reg.flags[RX_WATCHDOG_BIT], state_reg.flags[RX_STOPPED_BIT],
                      state_reg.flags[RX_DESC_UNAV_BIT], state_reg.flags[TX_UNDERFLOW_BIT],
                      state_reg.flags[TX_JABBER_BIT], state_reg.flags[TX_STOPPED_BIT]})
                   | ({set_ev[FATAL_BUS_BIT], set_ev[GP_TIMER_BIT], set_ev[RX_WATCHDOG_BIT],
                      set_ev[RX_STOPPED_BIT], set_ev[RX_DESC_UNAV_BIT], set_ev[TX_UNDERFLOW_BIT],
                      set_ev[TX_JABBER_BIT], set_ev[TX_STOPPED_BIT]}));
        set_ev[NORMAL_SUM_BIT]   = norm_any;
        set_ev[ABNORMAL_SUM_BIT] = abn_any;

        // Write one clears; a set in the same cycle wins
        clr_ev = wr_status ? i_wdata[16:0] : 17'h0_0000;
        state_next.flags = (state_reg.flags & ~clr_ev) | set_ev;

        // Software writes
        if (i_wr && i_addr == IRQ_MASK_OFS) begin
            state_next.irq_mask = {i_wdata[NORMAL_SUM_BIT], i_wdata[ABNORMAL_SUM_BIT]};
        end
        if (i_wr && i_addr == TX_RX_CTRL_OFS) begin
            state_next.ctrl = {i_wdata[TX_RUN_BIT], i_wdata[RX_RUN_BIT], i_wdata[TX_AUTOPOLL_BIT]};
        end

        // Read data, valid the cycle after the strobe
        state_next.rdata = 32'h0000_0000;
        if (i_rd) begin
            case (i_addr)
                DMA_EVENT_STATUS_OFS: begin
                    state_next.rdata[16:0] = state_reg.flags;
                    state_next.rdata[RX_STATE_LSB +: 3]  = state_reg.rx_state;
                    state_next.rdata[TX_STATE_LSB +: 3]  = state_reg.tx_state;
                    state_next.rdata[BUS_FAULT_LSB +: 3] = state_reg.fault_kind;
                end
                IRQ_MASK_OFS: begin
                    state_next.rdata[NORMAL_SUM_BIT]   = state_reg.irq_mask[1];
                    state_next.rdata[ABNORMAL_SUM_BIT] = state_reg.irq_mask[0];
                end
                TX_RX_CTRL_OFS: begin
                    state_next.rdata[TX_RUN_BIT]      = state_reg.ctrl[2];
                    state_next.rdata[RX_RUN_BIT]      = state_reg.ctrl[1];
                    state_next.rdata[TX_AUTOPOLL_BIT] = state_reg.ctrl[0];
                end
                default: begin
                end
            endcase
        end

        // The fault kind field is not an interrupt source
        state_next.irq = (state_next.flags[NORMAL_SUM_BIT] & state_next.irq_mask[1])
                       | (state_next.flags[ABNORMAL_SUM_BIT] & state_next.irq_mask[0]);
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_reg <= '{flags: STATUS_RESET[16:0], fault_kind: FAULT_PARITY, bus_blocked: 1'b0,
                           tx_state: TXS_STOPPED, rx_state: RXS_STOPPED, irq_mask: MASK_RESET,
                           ctrl: CTRL_RESET, rdata: STATUS_RESET, desc_we: 1'b0,
                           desc_word: STATUS_RESET, irq: 1'b0};
        end else begin
            state_reg <= state_next;
        end
    end

    assign o_rdata               = state_reg.rdata;
    assign o_bus_enable          = !state_reg.bus_blocked;
    assign o_tx_process_state    = state_reg.tx_state;
    assign o_rx_process_state    = state_reg.rx_state;
    assign o_tx_desc_status_we   = state_reg.desc_we;
    assign o_tx_desc_status_word = state_reg.desc_word;
    assign o_irq                 = state_reg.irq;

endmodule
`default_nettype wire

// ---- mds_host_model.sv ----
// Host driver model: register port master for the DMA event status block
`default_nettype none
module mds_host_model (
    input  wire logic        i_clk,
    input  wire logic [31:0] i_rdata,
    output var  logic [7:0]  o_addr,
    output var  logic [31:0] o_wdata,
    output var  logic        o_wr,
    output var  logic        o_rd
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        o_addr  = 8'h00;
        o_wdata = 32'h0000_0000;
        o_wr    = 1'b0;
        o_rd    = 1'b0;
    end
    // -----------------------------------------------------------------
    // Bus cycles
    // -----------------------------------------------------------------
    // Clears and poll demands are plain writes
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        o_addr  <= a;
        o_wdata <= d;
        o_wr    <= 1'b1;
        @(posedge i_clk);
        o_wr    <= 1'b0;
        #1;
    endtask
    // Read data stand only in the cycle after the strobe, so look then
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_rd   <= 1'b1;
        @(posedge i_clk);
        o_rd   <= 1'b0;
        #1;
        d = i_rdata;
    endtask
endmodule
`default_nettype wire

// ---- mds_dma_status_sva.sv ----
// Checker for the DMA event status block, bound to its ports
`default_nettype none
module mds_dma_status_sva
    import mds_pkg::*;
(
    input wire logic        i_clk,
    input wire logic        i_rstn,
    input wire logic        i_wr,
    input wire logic        i_soft_reset,
    input wire logic        i_bus_fault,
    input wire logic        i_tx_desc_fetched,
    input wire logic        i_tx_desc_owned,
    input wire logic        i_tx_fill_done,
    input wire logic        i_tx_underflow,
    input wire logic        i_tx_jabber,
    input wire logic        i_rx_desc_fetched,
    input wire logic        i_rx_desc_owned,
    input wire logic        i_rx_frame_checked,
    input wire logic        i_rx_frame_bad,
    input wire logic        o_bus_enable,
    input wire logic [2:0]  o_tx_process_state,
    input wire logic [2:0]  o_rx_process_state,
    input wire logic        o_tx_desc_status_we,
    input wire logic [31:0] o_tx_desc_status_word
);
    timeunit 1ns;
    timeprecision 1ps;
    // -----------------------------------------------------------------
    // Properties
    // -----------------------------------------------------------------
    // Writes and faults may redirect a process; step checks skip them
    logic calm;
    assign calm = o_bus_enable && !i_wr && !i_bus_fault && !i_tx_jabber;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    sequence s_tx_fill;
        o_tx_process_state == TXS_FILL && i_tx_fill_done && calm;
    endsequence
    sequence s_rx_bad;
        o_rx_process_state == RXS_CHECK && i_rx_frame_checked && i_rx_frame_bad && calm;
    endsequence
    sequence s_flush_back;
        o_rx_process_state == RXS_FLUSH ##1 o_rx_process_state == RXS_WAIT;
    endsequence
    a_fault_blocks_bus: assert property (i_bus_fault && !i_soft_reset |=> !o_bus_enable)
        else $error("bus still enabled after a fault");
    a_block_holds: assert property (!o_bus_enable && !i_soft_reset |=> !o_bus_enable)
        else $error("bus re-enabled without soft reset");
    a_jabber_stops_tx: assert property (i_tx_jabber |=> o_tx_process_state == TXS_STOPPED)
        else $error("transmit not stopped by jabber");
    a_jabber_desc_mark: assert property (i_tx_jabber && o_tx_process_state != TXS_STOPPED
        |=> o_tx_desc_status_we && o_tx_desc_status_word[DESC_JABBER_BIT]) else $error("jabber not marked");
    a_tx_unavail_susp: assert property (o_tx_process_state == TXS_READ_DESC && i_tx_desc_fetched
        && !i_tx_desc_owned && calm |=> o_tx_process_state == TXS_SUSPENDED) else $error("tx not suspended");
    a_underflow_susp: assert property (o_tx_process_state == TXS_SENDING && i_tx_underflow && calm
        |=> o_tx_process_state == TXS_SUSPENDED && o_tx_desc_status_we && o_tx_desc_status_word[DESC_UNDERFLOW_BIT])
        else $error("underflow not handled");
    a_rx_unavail_susp: assert property (o_rx_process_state == RXS_READ_DESC && i_rx_desc_fetched
        && !i_rx_desc_owned && calm |=> o_rx_process_state == RXS_SUSPENDED) else $error("rx not suspended");
    a_rx_flush_seq: assert property (s_rx_bad |=> s_flush_back)
        else $error("bad frame flush sequence wrong");
    a_tx_fill_send: assert property (s_tx_fill |=> o_tx_process_state == TXS_SENDING)
        else $error("fill done did not start sending");
    a_tx_state_codes: assert property (o_tx_process_state != 3'h4 && o_tx_process_state != 3'h5)
        else $error("reserved transmit state code");
endmodule
bind mds_dma_status mds_dma_status_sva u_sva (.*);
`default_nettype wire

// ---- mds_dma_status_tb.sv ----
// Self-checking testbench for the DMA event status block
`default_nettype none
module mds_dma_status_tb;
    import mds_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
    logic [31:0] rdata;
    logic [15:0] ev = 16'h0000;
    logic [6:0]  lvl = 7'h00;
    logic        bus_en;
    logic [2:0]  txs;
    logic [2:0]  rxs;
    logic        dwe;
    logic [31:0] dword;
    logic        irq;
    int          error_cnt = 0;
    int          n_compared = 0;
    always #2 clk = ~clk;
    mds_host_model u_host (.i_clk(clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd));
    // Event pulses share one vector; lvl carries owned/irq/bad levels and the fault kind
    mds_dma_status uut (.i_clk(clk), .i_rstn(rstn), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
        .o_rdata(rdata), .i_soft_reset(ev[0]), .i_bus_fault(ev[1]), .i_bus_fault_kind(lvl[6:4]),
        .i_gp_timer_expired(ev[2]), .i_rx_watchdog_expired(ev[3]), .i_tx_desc_fetched(ev[4]),
        .i_tx_desc_owned(lvl[0]), .i_tx_fill_done(ev[5]), .i_tx_underflow(ev[6]), .i_tx_jabber(ev[7]),
        .i_tx_frame_sent(ev[8]), .i_tx_irq_request(lvl[1]), .i_tx_desc_written(ev[9]), .i_rx_desc_fetched(ev[10]),
        .i_rx_desc_owned(lvl[2]), .i_rx_frame_start(ev[11]), .i_rx_frame_checked(ev[12]), .i_rx_frame_bad(lvl[3]),
        .i_rx_drain_done(ev[13]), .i_rx_desc_written(ev[14]), .i_tx_autopoll_tick(ev[15]), .o_bus_enable(bus_en),
        .o_tx_process_state(txs), .o_rx_process_state(rxs), .o_tx_desc_status_we(dwe),
        .o_tx_desc_status_word(dword), .o_irq(irq));
    // -----------------------------------------------------------------
    // Helpers
    // -----------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    localparam logic [31:0] FLG = 32'h1_ABEF;
    task automatic st(input logic [31:0] exp, input logic [31:0] m = FLG);
        logic [31:0] d;
        u_host.rd(DMA_EVENT_STATUS_OFS, d);
        chk("status", exp, d & m);
    endtask
    task automatic fire(input int b, input logic [6:0] lv);
        @(posedge clk);
        ev[b] <= 1'b1;
        lvl   <= lv;
        @(posedge clk);
        ev    <= 16'h0000;
        #1;
    endtask
    task automatic tick();
        @(posedge clk);
        #1;
    endtask
    // Sources first: a summary is re-set while any source stays set
    task automatic clr(input logic [31:0] f, input logic nrm);
        u_host.wr(DMA_EVENT_STATUS_OFS, f);
        u_host.wr(DMA_EVENT_STATUS_OFS, nrm ? 32'h1_0000 : 32'h8000);
    endtask
    // -----------------------------------------------------------------
    // Scenarios
    // -----------------------------------------------------------------
    task automatic t_reset();
        logic [31:0] d;
        st(STATUS_RESET, 32'hFFFF_FFFF);
        chk("bus_en", 1'h1, bus_en);
        u_host.rd(8'h3C, d);
        chk("unmapped", 32'h0, d);
    endtask
    task automatic t_timers();
        fire(2, 7'h00);
        fire(3, 7'h00);
        st(32'h8A00);
        chk("irq_masked", 1'h0, irq);
        u_host.wr(IRQ_MASK_OFS, 32'h8000);
        tick();
        chk("irq_abn", 1'h1, irq);
        u_host.wr(DMA_EVENT_STATUS_OFS, 32'h0);
        st(32'h8A00);
        u_host.wr(DMA_EVENT_STATUS_OFS, 32'h0800);
        st(32'h8200);
        clr(32'h0200, 1'h0);
        tick();
        chk("irq_clr", 1'h0, irq);
    endtask
    task automatic t_tx();
        u_host.wr(IRQ_MASK_OFS, 32'h1_8000);
        u_host.wr(TX_RX_CTRL_OFS, 32'h2000);
        tick();
        chk("tx_rd", TXS_READ_DESC, txs);
        fire(4, 7'h00);
        chk("tx_susp", TXS_SUSPENDED, txs);
        st(32'h1_0004);
        chk("irq_nrm", 1'h1, irq);
        clr(32'h0004, 1'h1);
        tick();
        chk("irq_off", 1'h0, irq);
        u_host.wr(TX_POLL_OFS, 32'h0);
        tick();
        chk("tx_poll", TXS_READ_DESC, txs);
        fire(4, 7'h01);
        chk("tx_fill", TXS_FILL, txs);
        fire(5, 7'h01);
        fire(8, 7'h03);
        chk("tx_wdsc", TXS_WRITE_DSC, txs);
        st(32'h1_0001);
        clr(32'h0001, 1'h1);
        fire(9, 7'h01);
        fire(4, 7'h01);
        fire(5, 7'h01);
        fire(8, 7'h01);
        fire(9, 7'h01);
        st(32'h0);
        fire(4, 7'h01);
        fire(5, 7'h01);
        fire(6, 7'h01);
        chk("uf_desc", 1'h1, dwe & dword[DESC_UNDERFLOW_BIT]);
        chk("tx_uf", TXS_SUSPENDED, txs);
        st(32'h8020);
        clr(32'h0020, 1'h0);
        u_host.wr(TX_RX_CTRL_OFS, 32'h2001);
        fire(15, 7'h01);
        chk("tx_apoll", TXS_READ_DESC, txs);
        fire(7, 7'h01);
        chk("jab_desc", 1'h1, dwe & dword[DESC_JABBER_BIT]);
        st(32'h800A);
        clr(32'h000A, 1'h0);
    endtask
    task automatic t_rx();
        // Clearing the transmit run bit here stops transmit as well
        u_host.wr(TX_RX_CTRL_OFS, 32'h0002);
        tick();
        chk("rx_rd", RXS_READ_DESC, rxs);
        fire(10, 7'h00);
        chk("rx_susp", RXS_SUSPENDED, rxs);
        st(32'h8082);
        clr(32'h0082, 1'h0);
        fire(11, 7'h00);
        chk("rx_frm", RXS_READ_DESC, rxs);
        fire(10, 7'h04);
        chk("rx_wait", RXS_WAIT, rxs);
        fire(11, 7'h04);
        chk("rx_drain", RXS_DRAIN, rxs);
        fire(13, 7'h04);
        chk("rx_check", RXS_CHECK, rxs);
        fire(12, 7'h0C);
        chk("rx_flush", RXS_FLUSH, rxs);
        fire(11, 7'h04);
        fire(13, 7'h04);
        fire(12, 7'h04);
        chk("rx_wdsc", RXS_WRITE_DSC, rxs);
        fire(14, 7'h04);
        st(32'h1_0040);
        clr(32'h0040, 1'h1);
        fire(10, 7'h00);
        u_host.wr(RX_POLL_OFS, 32'h0);
        tick();
        chk("rx_poll", RXS_READ_DESC, rxs);
        clr(32'h0080, 1'h0);
        u_host.wr(TX_RX_CTRL_OFS, 32'h0);
        tick();
        st(32'h8100);
        clr(32'h0100, 1'h0);
    endtask
    task automatic t_fault();
        for (int k = 0; k < 3; k++) begin
            fire(1, {3'(k), 4'h0});
            chk("bus_off", 1'h0, bus_en);
            st({6'h00, 3'(k), 23'h00_A000}, 32'h0380_A000);
            fire(1, 7'h30);
            st({6'h00, 3'(k), 23'h0}, 32'h0380_0000);
            fire(0, 7'h00);
            tick();
            chk("bus_on", 1'h1, bus_en);
            clr(32'h2000, 1'h0);
        end
    endtask
    // -----------------------------------------------------------------
    // Run control
    // -----------------------------------------------------------------
    task automatic conclude();
        if (error_cnt == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        conclude();
    end
    initial begin
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        t_reset();
        t_timers();
        t_tx();
        t_rx();
        t_fault();
        conclude();
    end
endmodule
`default_nettype wire
